// ### bench/adpcm_cfg_front_properties.sv
// core-domain checks on the ports of adpcm_cfg_front.
// assumes: bound to every instance; straps move only between tests.
`timescale 1ns/10ps
module adpcm_cfg_props (
  // clock, reset, pins
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       config_mode_select_i,
  input wire logic [5:0] device_id_strap_i,
  input wire logic       test_select_zero_i,
  input wire logic       test_select_one_i,
  input wire logic       config_serial_input_i,
  input wire logic       chip_select_n_i,
  input wire logic       x_pcm_data_out_oe_o,
  // engine side and status
  input wire logic [7:0] x_ctrl_o,
  input wire logic [7:0] y_ctrl_o,
  input wire logic [5:0] x_in_slot_o,
  input wire logic [5:0] y_out_slot_o,
  input wire logic       x_alg_reset_o,
  input wire logic       y_alg_reset_o,
  input wire logic       x_rx_valid_o,
  input wire logic       host_mode_o,
  input wire logic       standby_o,
  input wire logic       engine_run_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire [5:0] st = device_id_strap_i;
  wire [7:0] x_strap = {2'h0, chip_select_n_i, 2'h0, st[2], 1'b0, st[0]};
  wire [7:0] y_strap = {2'h0, config_serial_input_i, 2'h0, st[5], 1'b0, st[3]};
  // long enough for the pin syncs and the apply stage
  sequence strap_held;
    (!config_mode_select_i && $stable({st, chip_select_n_i, config_serial_input_i}))[*8];
  endsequence
  a_reset_ctrl_idle: assert property ($fell(rst_i) |-> x_ctrl_o == 8'h20 && y_ctrl_o == 8'h20)
    else $error("control not idle after reset");
  a_reset_alg_pulse: assert property ($fell(rst_i) |-> x_alg_reset_o && y_alg_reset_o
    ##1 !x_alg_reset_o && !y_alg_reset_o) else $error("algorithm reset not released");
  a_strap_map: assert property (strap_held |-> x_ctrl_o == x_strap && y_ctrl_o == y_strap)
    else $error("strap mapping wrong");
  a_strap_slots: assert property (strap_held |-> x_in_slot_o == 6'h00 && y_out_slot_o == 6'h00)
    else $error("strap slot not zero");
  a_mode_follow: assert property ($changed(config_mode_select_i)
    |-> ##[1:4] host_mode_o == config_mode_select_i) else $error("mode not followed");
  a_idle_no_drive: assert property (x_ctrl_o[5] [*8] |-> !x_pcm_data_out_oe_o)
    else $error("idle side drives");
  a_standby_both: assert property ($rose(x_ctrl_o[5] && y_ctrl_o[5]) |-> ##[0:2] standby_o)
    else $error("no standby");
  a_test_stop: assert property (test_select_zero_i || test_select_one_i |-> ##[0:3] !engine_run_o)
    else $error("engine runs in test");
  a_rx_one_cycle: assert property ($rose(x_rx_valid_o) |=> !x_rx_valid_o)
    else $error("rx valid too long");
  logic [3:0] quiet_q;
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i) quiet_q <= 4'h0;
    else quiet_q <= (host_mode_o && chip_select_n_i) ? quiet_q + {3'h0, quiet_q != 4'hc} : 4'h0;
  a_write_needs_cs: assert property (quiet_q == 4'hc
    |-> $stable(x_ctrl_o & 8'h2d) && $stable(y_ctrl_o & 8'h2d)) else $error("config moved");
endmodule

bind adpcm_cfg_front adpcm_cfg_props chk_u (.core_clk_i, .rst_i, .config_mode_select_i,
  .device_id_strap_i, .test_select_zero_i, .test_select_one_i, .config_serial_input_i,
  .chip_select_n_i, .x_pcm_data_out_oe_o, .x_ctrl_o, .y_ctrl_o, .x_in_slot_o, .y_out_slot_o,
  .x_alg_reset_o, .y_alg_reset_o, .x_rx_valid_o, .host_mode_o, .standby_o, .engine_run_o);

// ### bench/adpcm_pcm_partner.sv
// codec stand-in: bit clock, frame sync, one byte each way in slot 0.
// assumes: the device side runs slot 0 byte wide.
`timescale 1ns/10ps
module adpcm_pcm_partner #(
  parameter int FRAME_BITS = 32
) (
  // bench side
  input  wire logic       run_i,
  input  wire logic [7:0] tx_byte_i,
  output logic [7:0]      rx_byte_o,
  // pcm pins
  output logic            bit_clk_o,
  output logic            frame_sync_o,
  output logic            data_o,
  input  wire logic       data_i
);
  logic [5:0] cnt_q;
  initial begin
    bit_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    data_o = 1'b0;
    cnt_q = 6'h00;
    rx_byte_o = 8'h00;
  end
  // 12 ns clock, stands low while not running
  always begin
    #6;
    bit_clk_o = run_i ? ~bit_clk_o : 1'b0;
  end
  // frame far shorter than 8 khz to keep the run brief
  always @(posedge bit_clk_o) begin
    cnt_q <= (cnt_q == FRAME_BITS - 1) ? 6'h00 : cnt_q + 6'h01;
    frame_sync_o <= (cnt_q == FRAME_BITS - 1);
    data_o <= (cnt_q < 6'h08) ? tx_byte_i[3'h7 - cnt_q[2:0]] : ~data_o;
  end
  always @(negedge bit_clk_o) begin
    if (cnt_q >= 6'h01 && cnt_q <= 6'h08)
      rx_byte_o <= {rx_byte_o[6:0], data_i};
  end
endmodule

// ### bench/testbench.sv
// bench for adpcm_cfg_front: strap table, serial writes, pcm slot 0.
// assumes: two codec stand-ins on the pcm sides.
`timescale 1ns/10ps
module testbench;
  logic       core_clk_i = 1'b0, rst_i = 1'b1, mode_q = 1'b0, sclk_q = 1'b0;
  logic       ser_in_q = 1'b0, cs_n_q = 1'b0, xload_q = 1'b0;
  logic [5:0] strap_q = 6'h00;
  logic [1:0] test_q = 2'h0;
  logic [7:0] xtx_q = 8'h00;
  logic       xbclk, xfs, xdin, xdout, ybclk, yfs, ydin, ydout, xrv, hm, sb, er;
  logic [7:0] x_ctrl, y_ctrl, x_rx, prx;
  logic [5:0] xis, xos, yis, yos;
  int         n_errors = 0, n_compared = 0, cycles = 0;
  // straps, cs_n, serial in, expected x ctrl, expected y ctrl
  logic [23:0] rows [9] = '{24'h000000, 24'h040100, 24'h100400, 24'h200001, 24'h800004,
                            24'h022000, 24'h010020, 24'hb72525, 24'h000000};
  always #5 core_clk_i = ~core_clk_i;
  adpcm_cfg_front dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .config_mode_select_i(mode_q), .device_id_strap_i(strap_q),
    .test_select_zero_i(test_q[0]), .test_select_one_i(test_q[1]), .sclk_i(sclk_q),
    .config_serial_input_i(ser_in_q), .chip_select_n_i(cs_n_q),
    .x_pcm_bit_clock_i(xbclk), .x_frame_sync_i(xfs), .x_pcm_data_in_i(xdin),
    .x_pcm_data_out_o(xdout), .x_pcm_data_out_oe_o(),
    .y_pcm_bit_clock_i(ybclk), .y_frame_sync_i(yfs), .y_pcm_data_in_i(ydin),
    .y_pcm_data_out_o(ydout), .y_pcm_data_out_oe_o(),
    .x_ctrl_o(x_ctrl), .x_in_slot_o(xis), .x_out_slot_o(xos), .x_alg_reset_o(),
    .x_rx_word_o(x_rx), .x_rx_valid_o(xrv), .x_tx_word_i(xtx_q), .x_tx_load_i(xload_q),
    .y_ctrl_o(y_ctrl), .y_in_slot_o(yis), .y_out_slot_o(yos), .y_alg_reset_o(),
    .y_rx_word_o(), .y_rx_valid_o(), .y_tx_word_i(xtx_q), .y_tx_load_i(xload_q),
    .host_mode_o(hm), .standby_o(sb), .engine_run_o(er));
  adpcm_pcm_partner px_u (.run_i(1'b1), .tx_byte_i(8'ha5), .rx_byte_o(prx),
    .bit_clk_o(xbclk), .frame_sync_o(xfs), .data_o(xdin), .data_i(xdout));
  adpcm_pcm_partner py_u (.run_i(1'b1), .tx_byte_i(8'h5a), .rx_byte_o(),
    .bit_clk_o(ybclk), .frame_sync_o(yfs), .data_o(ydin), .data_i(ydout));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic ser_write(input logic [31:0] w, input int n);
    cs_n_q <= 1'b0;
    for (int i = 0; i < n; i++) begin
      ser_in_q <= w[31 - i];
      cyc(2);
      sclk_q <= 1'b1;
      cyc(2);
      sclk_q <= 1'b0;
    end
    cyc(2);
    cs_n_q <= 1'b1;
    cyc(12);
  endtask
  // seen at the falling core edge so the pulse is settled
  task automatic wait_rx();
    repeat (200) begin
      @(negedge core_clk_i);
      if (xrv === 1'b1) break;
    end
    chk({7'h0, xrv}, 8'h01);
    @(posedge core_clk_i);
  endtask

  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    cyc(4);
    chk(x_ctrl, 8'h20);
    chk(y_ctrl, 8'h20);
    chk({6'h0, sb, er}, 8'h02);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      {strap_q, cs_n_q, ser_in_q} <= rows[i][23:16];
      cyc(10);
      chk(x_ctrl, rows[i][15:8]);
      chk(y_ctrl, rows[i][7:0]);
      chk({2'h0, xis | xos | yis | yos}, 8'h00);
    end
    mode_q <= 1'b1;
    cs_n_q <= 1'b1;
    strap_q <= 6'h16;
    cyc(10);
    rst_i <= 1'b1;
    cyc(4);
    rst_i <= 1'b0;
    cyc(6);
    chk({6'h0, hm, sb}, 8'h03);
    ser_write({8'h56, 8'h01, 8'h05, 8'h03}, 32);
    chk(x_ctrl, 8'h01);
    chk({xis, xos[5:4]}, {6'h05, 2'h0});
    chk({2'h0, xos}, 8'h03);
    chk(y_ctrl, 8'h20);
    ser_write({8'h57, 8'h20, 8'h00, 8'h00}, 32);
    ser_write({8'h16, 8'h05, 8'h00, 8'h00}, 16);
    chk(x_ctrl, 8'h01);
    chk(y_ctrl, 8'h20);
    ser_write({8'h16, 8'h05, 8'h00, 8'h00}, 32);
    chk(y_ctrl, 8'h05);
    ser_write({8'h56, 8'h01, 8'h00, 8'h00}, 32);
    xtx_q <= 8'h3c;
    xload_q <= 1'b1;
    cyc(1);
    xload_q <= 1'b0;
    wait_rx();
    wait_rx();
    chk(x_rx, 8'ha5);
    chk(prx, 8'h3c);
    chk({6'h0, sb, er}, 8'h01);
    test_q <= 2'h2;
    cyc(6);
    chk({7'h0, er}, 8'h00);
    test_q <= 2'h0;
    cyc(2);
    final_report();
  end
endmodule

// ### src/adpcm_cfg_front.sv
// adpcm_cfg_front: configuration front end of the dual adpcm processor.
// assumes: core_clk_i is the 100 mhz engine clock; serial and pcm clocks
// are unrelated to it; the engine consumes cfg and pcm words below.
//
// Summary of operation
// [R1] reset clears registers, restarts both algorithms
// [R2] host holds reset 1 ms after clock
// [R3] host pulses reset on mode change
// [R4] reset clears control except idle, set both
// [R5] mode select high host, low strap
// [R6] strap mode: serial off, registers cleared, pins
// [R7] strap mode slots fixed at zero
// [R8] strap coding: bit0 x, bit3 y
// [R9] strap law: bit2 x, bit5 y
// [R10] strap idle: serial in y, select x
// [R11] pcm input sampled on falling edge, in-slot
// [R12] pcm output changes rising edge, out-slot
// [R13] bit clock coherent, rising aligned with sync
// [R14] frame sync at 8 khz each side
// [R15] engine clock asynchronous to other clocks
// [R16] serial data captured on serial clock rise
// [R17] write accepted only while select low
// [R18] address byte must equal id straps
// [R19] test select inputs tied low
// [R20] three bytes follow; bit six picks side
// [R21] timeslots counted from frame sync rise
// [R22] both sides idle enters standby
// [R23] serial writes synchronised into engine clock
// [R24] mismatched transfer ignored until select rises
`timescale 1ns/10ps
`include "adpcm_params.svh"

module adpcm_cfg_front (
  // engine clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // straps and mode
  input  wire logic       config_mode_select_i,
  input  wire logic [5:0] device_id_strap_i,
  input  wire logic       test_select_zero_i,
  input  wire logic       test_select_one_i,
  // serial configuration port
  input  wire logic       sclk_i,
  input  wire logic       config_serial_input_i,
  input  wire logic       chip_select_n_i,
  // x pcm interface
  input  wire logic       x_pcm_bit_clock_i,
  input  wire logic       x_frame_sync_i,
  input  wire logic       x_pcm_data_in_i,
  output logic            x_pcm_data_out_o,
  output logic            x_pcm_data_out_oe_o,
  // y pcm interface
  input  wire logic       y_pcm_bit_clock_i,
  input  wire logic       y_frame_sync_i,
  input  wire logic       y_pcm_data_in_i,
  output logic            y_pcm_data_out_o,
  output logic            y_pcm_data_out_oe_o,
  // engine side, x
  output logic [7:0]      x_ctrl_o,
  output logic [5:0]      x_in_slot_o,
  output logic [5:0]      x_out_slot_o,
  output logic            x_alg_reset_o,
  output logic [7:0]      x_rx_word_o,
  output logic            x_rx_valid_o,
  input  wire logic [7:0] x_tx_word_i,
  input  wire logic       x_tx_load_i,
  // engine side, y
  output logic [7:0]      y_ctrl_o,
  output logic [5:0]      y_in_slot_o,
  output logic [5:0]      y_out_slot_o,
  output logic            y_alg_reset_o,
  output logic [7:0]      y_rx_word_o,
  output logic            y_rx_valid_o,
  input  wire logic [7:0] y_tx_word_i,
  input  wire logic       y_tx_load_i,
  // status
  output logic            host_mode_o,
  output logic            standby_o,
  output logic            engine_run_o
);

  // ----------------------------------------------------------------------
  // pin synchronisers into the engine clock
  // ----------------------------------------------------------------------
  // mode resets to host, so the idle reset value stands until straps are seen
  logic [10:0] pin_s1_q;
  logic [10:0] pin_s2_q;
  wire  [10:0] pin_raw = {test_select_one_i, test_select_zero_i, chip_select_n_i,
                          config_serial_input_i, config_mode_select_i,
                          device_id_strap_i};

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= 11'h040;
      pin_s2_q <= 11'h040;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire [5:0] addr_s    = pin_s2_q[5:0];
  wire       host_mode = pin_s2_q[6]; // R5
  wire       ser_in_s  = pin_s2_q[7];
  wire       cs_n_s    = pin_s2_q[8];
  wire       test_s    = pin_s2_q[9] | pin_s2_q[10];

  // ----------------------------------------------------------------------
  // serial port, serial clock domain
  // ----------------------------------------------------------------------
  // select high or strap mode holds the shifter cleared, so a
  // mismatched or short transfer leaves nothing behind
  logic [30:0] ser_sh_q;
  logic [5:0]  ser_cnt_q;
  logic [31:0] ser_word_q;
  logic        ser_tgl_q;
  wire         ser_rst  = rst_i | chip_select_n_i | ~config_mode_select_i; // R17 R6 R24
  wire         ser_last = ~ser_rst & (ser_cnt_q == `ADPCM_SER_LAST);

  always_ff @(posedge sclk_i or posedge ser_rst) begin
    if (ser_rst) begin
      ser_sh_q  <= 31'h00000000;
      ser_cnt_q <= 6'h00;
    end else if (ser_cnt_q != `ADPCM_SER_FULL) begin
      ser_sh_q  <= {ser_sh_q[29:0], config_serial_input_i}; // R16
      ser_cnt_q <= ser_cnt_q + 6'h01;
    end
  end

  // held word survives the select rising right after the last bit
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      ser_word_q <= 32'h00000000;
      ser_tgl_q  <= 1'b0;
    end else if (ser_last) begin
      ser_word_q <= {ser_sh_q, config_serial_input_i};
      ser_tgl_q  <= ~ser_tgl_q;
    end
  end

  // ----------------------------------------------------------------------
  // write word into the engine clock
  // ----------------------------------------------------------------------
  logic [2:0] wr_sync_q;
  wire        wr_new = wr_sync_q[2] ^ wr_sync_q[1];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_sync_q <= 3'h0;
    end else begin
      wr_sync_q <= {wr_sync_q[1:0], ser_tgl_q}; // R23
    end
  end

  // word is stable for many engine cycles once its toggle is seen
  wire [7:0] cmd_byte = ser_word_q[31:24]; // R20
  wire [7:0] wr_ctrl  = ser_word_q[23:16];
  wire [7:0] wr_islot = ser_word_q[15:8];
  wire [7:0] wr_oslot = ser_word_q[7:0];
  wire       wr_match = cmd_byte[5:0] == addr_s; // R18
  wire       wr_ok    = wr_new & host_mode & wr_match; // R24

  // ----------------------------------------------------------------------
  // strap mapping
  // ----------------------------------------------------------------------
  function automatic logic [7:0] strap_ctrl(input logic idle, input logic law,
                                            input logic code);
    logic [7:0] c;
    c                 = 8'h00;
    c[`ADPCM_CR_IDLE] = idle;
    c[`ADPCM_CR_LAW]  = law;
    c[`ADPCM_CR_CODE] = code;
    strap_ctrl        = c;
  endfunction

  adpcm_pkg::adpcm_side_cfg_type strap_cfg [2];

  assign strap_cfg[adpcm_pkg::ADPCM_SIDE_X] = {
    strap_ctrl(cs_n_s, addr_s[`ADPCM_STRAP_X_LAW], addr_s[`ADPCM_STRAP_X_CODE]), // R8 R9 R10
    `ADPCM_SLOT_RESET, `ADPCM_SLOT_RESET}; // R7
  assign strap_cfg[adpcm_pkg::ADPCM_SIDE_Y] = {
    strap_ctrl(ser_in_s, addr_s[`ADPCM_STRAP_Y_LAW], addr_s[`ADPCM_STRAP_Y_CODE]), // R8 R9 R10
    `ADPCM_SLOT_RESET, `ADPCM_SLOT_RESET}; // R7

  // ----------------------------------------------------------------------
  // per-side arrays, index 1 is x as in the address/command byte
  // ----------------------------------------------------------------------
  logic [1:0] bclk;
  logic [1:0] fsync;
  logic [1:0] din;
  logic [1:0] dout;
  logic [1:0] doe;
  logic [7:0] tx_word [2];
  logic [1:0] tx_load;
  logic [7:0] rx_side [2];
  logic [1:0] rx_tgl;

  adpcm_pkg::adpcm_side_cfg_type host_cfg_q [2];
  adpcm_pkg::adpcm_side_cfg_type eff_cfg    [2];
  adpcm_pkg::adpcm_side_cfg_type snap_q     [2];
  adpcm_pkg::adpcm_push_state_type push_q   [2];
  logic [3:0] hold_q  [2];
  logic [1:0] cfg_tgl_q;
  logic [1:0] alg_rst_q;
  logic [7:0] tx_q    [2];
  logic [1:0] tx_tgl_q;
  logic [2:0] rx_sync_q [2];
  logic [7:0] rx_q    [2];
  logic [1:0] rx_valid_q;

  assign bclk    = {x_pcm_bit_clock_i, y_pcm_bit_clock_i};
  assign fsync   = {x_frame_sync_i, y_frame_sync_i};
  assign din     = {x_pcm_data_in_i, y_pcm_data_in_i};
  assign tx_word[1] = x_tx_word_i;
  assign tx_word[0] = y_tx_word_i;
  assign tx_load = {x_tx_load_i, y_tx_load_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_side
      wire sel     = cmd_byte[`ADPCM_CMD_SIDE] == 1'(g);
      wire rx_new  = rx_sync_q[g][2] ^ rx_sync_q[g][1];
      wire changed = eff_cfg[g] != snap_q[g];

      assign eff_cfg[g] = host_mode ? host_cfg_q[g] : strap_cfg[g];

      // host copy of control and timeslot bytes
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          host_cfg_q[g] <= {`ADPCM_CR_RESET, `ADPCM_SLOT_RESET, `ADPCM_SLOT_RESET}; // R1 R4
        end else if (!host_mode) begin
          host_cfg_q[g] <= '0; // R6
        end else if (wr_ok && sel) begin
          host_cfg_q[g] <= {wr_ctrl & `ADPCM_CR_MASK, wr_islot[5:0], wr_oslot[5:0]}; // R20
        end else if (host_cfg_q[g].ctrl[`ADPCM_CR_ALRST]) begin
          host_cfg_q[g].ctrl[`ADPCM_CR_ALRST] <= 1'b0;
        end
      end

      // algorithm restart: held through reset, then one cycle per request
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          alg_rst_q[g] <= 1'b1; // R1
        end else begin
          alg_rst_q[g] <= host_mode & host_cfg_q[g].ctrl[`ADPCM_CR_ALRST];
        end
      end

      // snapshot pushed to the link domain; held stable while it crosses
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          snap_q[g]    <= {`ADPCM_CR_RESET, `ADPCM_SLOT_RESET, `ADPCM_SLOT_RESET}; // R4
          cfg_tgl_q[g] <= 1'b0;
          hold_q[g]    <= 4'h0;
          push_q[g]    <= adpcm_pkg::ADPCM_PUSH_IDLE;
        end else begin
          case (push_q[g])
            adpcm_pkg::ADPCM_PUSH_IDLE: begin
              if (changed) begin
                snap_q[g]    <= eff_cfg[g];
                cfg_tgl_q[g] <= ~cfg_tgl_q[g]; // R15
                hold_q[g]    <= `ADPCM_PUSH_HOLD;
                push_q[g]    <= adpcm_pkg::ADPCM_PUSH_HOLD;
              end
            end
            adpcm_pkg::ADPCM_PUSH_HOLD: begin
              hold_q[g] <= hold_q[g] - 4'h1;
              if (hold_q[g] == 4'h1) push_q[g] <= adpcm_pkg::ADPCM_PUSH_IDLE;
            end
            default: push_q[g] <= adpcm_pkg::ADPCM_PUSH_IDLE;
          endcase
        end
      end

      // transmit word from the engine, and received word back to it
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          tx_q[g]       <= 8'h00;
          tx_tgl_q[g]   <= 1'b0;
          rx_sync_q[g]  <= 3'h0;
          rx_q[g]       <= 8'h00;
          rx_valid_q[g] <= 1'b0;
        end else begin
          if (tx_load[g]) begin
            tx_q[g]     <= tx_word[g];
            tx_tgl_q[g] <= ~tx_tgl_q[g];
          end
          rx_sync_q[g]  <= {rx_sync_q[g][1:0], rx_tgl[g]}; // R15
          rx_valid_q[g] <= rx_new;
          if (rx_new) rx_q[g] <= rx_side[g];
        end
      end

      adpcm_pcm_side u_side (
        .rst_i        (rst_i),
        .bit_clk_i    (bclk[g]),
        .frame_sync_i (fsync[g]),
        .data_i       (din[g]),
        .data_o       (dout[g]),
        .data_oe_o    (doe[g]),
        .cfg_i        (snap_q[g]),
        .cfg_tgl_i    (cfg_tgl_q[g]),
        .tx_word_i    (tx_q[g]),
        .tx_tgl_i     (tx_tgl_q[g]),
        .rx_word_o    (rx_side[g]),
        .rx_tgl_o     (rx_tgl[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // status
  // ----------------------------------------------------------------------
  logic standby_q;
  logic run_q;
  logic host_q;
  wire  both_idle = snap_q[1].ctrl[`ADPCM_CR_IDLE] & snap_q[0].ctrl[`ADPCM_CR_IDLE];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      standby_q <= 1'b1; // R4
      run_q     <= 1'b0;
      host_q    <= 1'b0;
    end else begin
      standby_q <= both_idle; // R22
      run_q     <= ~both_idle & ~test_s; // R19
      host_q    <= host_mode;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign x_pcm_data_out_o    = dout[1];
  assign x_pcm_data_out_oe_o = doe[1];
  assign y_pcm_data_out_o    = dout[0];
  assign y_pcm_data_out_oe_o = doe[0];
  assign x_ctrl_o     = snap_q[1].ctrl;
  assign x_in_slot_o  = snap_q[1].in_slot;
  assign x_out_slot_o = snap_q[1].out_slot;
  assign x_alg_reset_o = alg_rst_q[1];
  assign x_rx_word_o  = rx_q[1];
  assign x_rx_valid_o = rx_valid_q[1];
  assign y_ctrl_o     = snap_q[0].ctrl;
  assign y_in_slot_o  = snap_q[0].in_slot;
  assign y_out_slot_o = snap_q[0].out_slot;
  assign y_alg_reset_o = alg_rst_q[0];
  assign y_rx_word_o  = rx_q[0];
  assign y_rx_valid_o = rx_valid_q[0];
  assign host_mode_o  = host_q;
  assign standby_o    = standby_q;
  assign engine_run_o = run_q;

endmodule

// ### src/adpcm_params.svh
// adpcm_params.svh: bit positions, reset values and counts of the
// configuration front end.
// assumes: included by bare name from every design file that needs it.
`ifndef ADPCM_PARAMS_SVH
`define ADPCM_PARAMS_SVH

// ----------------------------------------------------------------------
// control byte fields
// ----------------------------------------------------------------------
`define ADPCM_CR_IDLE     5
`define ADPCM_CR_ALRST    4
`define ADPCM_CR_BYP      3
`define ADPCM_CR_LAW      2
`define ADPCM_CR_CODE     0
`define ADPCM_CR_MASK     8'h3d
`define ADPCM_CR_RESET    8'h20
`define ADPCM_SLOT_RESET  6'h00

// ----------------------------------------------------------------------
// address/command byte and serial framing
// ----------------------------------------------------------------------
`define ADPCM_CMD_SIDE    6
`define ADPCM_SER_LAST    6'h1f
`define ADPCM_SER_FULL    6'h20

// ----------------------------------------------------------------------
// strap positions on the device id inputs
// ----------------------------------------------------------------------
`define ADPCM_STRAP_X_CODE 0
`define ADPCM_STRAP_X_LAW  2
`define ADPCM_STRAP_Y_CODE 3
`define ADPCM_STRAP_Y_LAW  5

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
// a pushed config word stays stable this many core cycles
`define ADPCM_PUSH_HOLD   4'h8

`endif

// ### src/adpcm_pcm_side.sv
// adpcm_pcm_side: one tdm pcm interface on its own bit clock.
// assumes: cfg_i and tx_word_i stay stable while their toggles settle;
// frame sync is coherent with the bit clock.
`timescale 1ns/10ps
`include "adpcm_params.svh"

module adpcm_pcm_side (
  // clock and reset
  input  wire logic                       rst_i,
  input  wire logic                       bit_clk_i,
  // pins
  input  wire logic                       frame_sync_i,
  input  wire logic                       data_i,
  output logic                            data_o,
  output logic                            data_oe_o,
  // from core domain
  input  wire adpcm_pkg::adpcm_side_cfg_type cfg_i,
  input  wire logic                       cfg_tgl_i,
  input  wire logic [7:0]                 tx_word_i,
  input  wire logic                       tx_tgl_i,
  // to core domain
  output logic [7:0]                      rx_word_o,
  output logic                            rx_tgl_o
);

  // ----------------------------------------------------------------------
  // crossings from core domain
  // ----------------------------------------------------------------------
  logic [2:0]                    cfg_sync_q;
  logic [2:0]                    tx_sync_q;
  adpcm_pkg::adpcm_side_cfg_type cfg_q;
  logic [7:0]                    tx_q;
  wire                           cfg_new = cfg_sync_q[2] ^ cfg_sync_q[1];
  wire                           tx_new  = tx_sync_q[2] ^ tx_sync_q[1];

  always_ff @(posedge bit_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_sync_q <= 3'h0;
      tx_sync_q  <= 3'h0;
      cfg_q      <= {`ADPCM_CR_RESET, `ADPCM_SLOT_RESET, `ADPCM_SLOT_RESET};
      tx_q       <= 8'h00;
    end else begin
      cfg_sync_q <= {cfg_sync_q[1:0], cfg_tgl_i}; // R15
      tx_sync_q  <= {tx_sync_q[1:0], tx_tgl_i};
      if (cfg_new) cfg_q <= cfg_i;
      if (tx_new) tx_q <= tx_word_i;
    end
  end

  // ----------------------------------------------------------------------
  // timeslot counting
  // ----------------------------------------------------------------------
  // wide slots hold pcm bytes when compressing, nibbles otherwise
  function automatic logic slot_hit(input logic [9:0] idx, input logic wide,
                                    input logic [5:0] slot);
    slot_hit = wide ? (idx[9:3] == {1'b0, slot}) : (idx[9:2] == {2'b00, slot});
  endfunction

  function automatic logic [2:0] slot_pos(input logic [9:0] idx, input logic wide);
    slot_pos = wide ? idx[2:0] : {1'b0, idx[1:0]};
  endfunction

  logic       fs_q;
  logic [9:0] bit_q;
  wire        wide     = cfg_q.ctrl[`ADPCM_CR_CODE];
  wire        idle     = cfg_q.ctrl[`ADPCM_CR_IDLE];
  wire        fs_start = frame_sync_i & ~fs_q;
  wire [9:0]  bit_d    = fs_start ? 10'h000 : bit_q + 10'h001; // R21
  wire        out_hit  = slot_hit(bit_d, wide, cfg_q.out_slot) & ~idle;
  wire [2:0]  out_pos  = slot_pos(bit_d, wide);
  wire [7:0]  tx_sel   = wide ? tx_q : {tx_q[3:0], 4'h0};

  // ----------------------------------------------------------------------
  // output on rising edge
  // ----------------------------------------------------------------------
  always_ff @(posedge bit_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fs_q      <= 1'b0;
      bit_q     <= 10'h000;
      data_o    <= 1'b0;
      data_oe_o <= 1'b0;
    end else begin
      fs_q      <= frame_sync_i;
      bit_q     <= bit_d;
      data_oe_o <= out_hit;
      if (out_hit) data_o <= tx_sel[3'h7 - out_pos]; // R12
    end
  end

  // ----------------------------------------------------------------------
  // input on falling edge
  // ----------------------------------------------------------------------
  logic [6:0] rx_sh_q;
  wire        in_hit  = slot_hit(bit_q, wide, cfg_q.in_slot) & ~idle;
  wire [2:0]  in_pos  = slot_pos(bit_q, wide);
  wire        in_last = wide ? (in_pos == 3'h7) : (in_pos == 3'h3);
  wire [7:0]  rx_full = {rx_sh_q, data_i};

  always_ff @(negedge bit_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sh_q   <= 7'h00;
      rx_word_o <= 8'h00;
      rx_tgl_o  <= 1'b0;
    end else if (in_hit) begin
      rx_sh_q <= rx_full[6:0]; // R11
      if (in_last) begin
        rx_word_o <= wide ? rx_full : {4'h0, rx_full[3:0]};
        rx_tgl_o  <= ~rx_tgl_o;
      end
    end
  end

endmodule

// ### src/adpcm_pkg.sv
// adpcm_pkg: types shared by the configuration front end.
// assumes: constants live in adpcm_params.svh.
package adpcm_pkg;

  // ----------------------------------------------------------------------
  // per-side configuration word
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [5:0] in_slot;
    logic [5:0] out_slot;
  } adpcm_side_cfg_type;

  // side select as carried in the address/command byte
  typedef enum logic {
    ADPCM_SIDE_Y,
    ADPCM_SIDE_X
  } adpcm_side_type;

  // config push into the link domain
  typedef enum {
    ADPCM_PUSH_IDLE,
    ADPCM_PUSH_HOLD
  } adpcm_push_state_type;

endpackage
